// >>> include/mlft_pkg.sv
/*
 * Holds the constants, commands and states of the forwarding table.
 * Assumes a single switch clock at 25 MHz.
 */
`default_nettype none
package mlft_pkg;
	localparam int unsigned MLFT_CLK_HZ = 25_000_000;
	localparam int MLFT_MAC_W = 48;
	localparam int MLFT_VID_W = 13;
	localparam int MLFT_AGE_W = 10;
	localparam int MLFT_CMD_W = 3;
	localparam logic [MLFT_AGE_W-1:0] MLFT_AGE_RESET_S = 10'h12C;
	localparam logic [MLFT_AGE_W-1:0] MLFT_AGE_ONE = 10'h001;
	localparam logic [MLFT_AGE_W-1:0] MLFT_AGE_ZERO = 10'h000;
	localparam logic [MLFT_CMD_W-1:0] MLFT_CMD_ADD_STATIC = 3'h1;
	localparam logic [MLFT_CMD_W-1:0] MLFT_CMD_DELETE = 3'h2;
	localparam logic [MLFT_CMD_W-1:0] MLFT_CMD_ADD_FILTER = 3'h3;
	localparam logic [MLFT_CMD_W-1:0] MLFT_CMD_FLUSH = 3'h4;
	localparam logic [MLFT_CMD_W-1:0] MLFT_CMD_PROMOTE = 3'h5;
	localparam logic [MLFT_CMD_W-1:0] MLFT_CMD_READ_NEXT = 3'h6;
	localparam logic [MLFT_CMD_W-1:0] MLFT_CMD_SET_AGE = 3'h7;
	typedef enum logic [1:0] {MLFT_KIND_FREE, MLFT_KIND_DYNAMIC, MLFT_KIND_STATIC, MLFT_KIND_FILTER} mlft_kind_e;
endpackage
`default_nettype wire

// >>> rtl/mlft_table.sv
/*
 * Forwarding table with learning, aging, filters and management commands.
 * Assumes frame and management requests come from logic on the same clock.
 */
`default_nettype none
// Contract
// - Egress chosen by destination MAC lookup
// - Entry maps MAC and VLAN to ports
// - Entries are static or dynamic, typed
// - Source MAC learns or refreshes dynamic entry
// - Idle dynamic entries removed after aging
// - Aging time in seconds, reset 300
// - Static entries kept until deleted
// - Enumeration ordered by VLAN then MAC
// - Frames matching filter entry are dropped
// - Flush clears all dynamic entries only
// - Promote turns dynamic entry into static
// - Delete invalidates the named entry
// - Read returns next entry after key
// - Read reports MAC, VLAN, type, ports
module mlft_table #(
	parameter int DEPTH = 16,
	parameter int PORTS = 8,
	parameter int unsigned CYCLES_PER_SEC = mlft_pkg::MLFT_CLK_HZ
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_frm_valid,
	input wire logic [mlft_pkg::MLFT_MAC_W-1:0] i_destination_mac_key,
	input wire logic [mlft_pkg::MLFT_MAC_W-1:0] i_source_mac_key,
	input wire logic [mlft_pkg::MLFT_VID_W-1:0] i_frm_vid,
	input wire logic [PORTS-1:0] i_frm_ingress,
	input wire logic [PORTS-1:0] i_vlan_members,
	output logic o_fwd_valid,
	output logic o_fwd_drop,
	output logic o_fwd_flood,
	output logic [PORTS-1:0] o_fwd_ports,
	input wire logic i_cmd_valid,
	input wire logic [mlft_pkg::MLFT_CMD_W-1:0] i_cmd_op,
	input wire logic [mlft_pkg::MLFT_MAC_W-1:0] i_cmd_mac,
	input wire logic [mlft_pkg::MLFT_VID_W-1:0] i_cmd_vid,
	input wire logic [PORTS-1:0] i_cmd_ports,
	input wire logic [mlft_pkg::MLFT_AGE_W-1:0] i_cmd_age,
	output logic o_cmd_done,
	output logic o_rd_found,
	output logic [mlft_pkg::MLFT_MAC_W-1:0] o_rd_mac,
	output logic [mlft_pkg::MLFT_VID_W-1:0] o_rd_vid,
	output logic o_rd_static,
	output logic [PORTS-1:0] o_rd_ports,
	output logic [mlft_pkg::MLFT_AGE_W-1:0] o_age_time
);
	import mlft_pkg::*;
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int KW = MLFT_VID_W + MLFT_MAC_W;
	localparam int TW = (CYCLES_PER_SEC > 1) ? $clog2(CYCLES_PER_SEC) : 1;
	localparam logic [TW-1:0] TICK_LAST = TW'(CYCLES_PER_SEC - 1);

	// ----------------------------------------------------------------
	// Table storage
	// ----------------------------------------------------------------
	logic [MLFT_MAC_W-1:0] mac_q [DEPTH];
	logic [MLFT_VID_W-1:0] vid_q [DEPTH];
	logic [PORTS-1:0] ports_q [DEPTH];
	mlft_kind_e kind_q [DEPTH];
	logic [MLFT_AGE_W-1:0] idle_q [DEPTH];
	logic [MLFT_AGE_W-1:0] age_time_q;
	logic [TW-1:0] tick_cnt_q;
	logic sec_tick;

	// ----------------------------------------------------------------
	// Lookup and search
	// ----------------------------------------------------------------
	logic [DEPTH-1:0] dst_hit, src_hit, flt_hit, cmd_hit, free_v, after_v;
	logic [IW-1:0] dst_idx, src_idx, cmd_idx, free_idx, nxt_idx;
	logic dst_any, flt_any, src_any, cmd_any, free_any, nxt_any;
	logic [KW-1:0] cmd_key, best_key;
	assign cmd_key = {i_cmd_vid, i_cmd_mac};

	always_comb begin
		dst_idx = '0;
		src_idx = '0;
		cmd_idx = '0;
		free_idx = '0;
		nxt_idx = '0;
		dst_any = 1'b0;
		src_any = 1'b0;
		cmd_any = 1'b0;
		free_any = 1'b0;
		nxt_any = 1'b0;
		best_key = '1;
		for (int i = 0; i < DEPTH; i++) begin
			dst_hit[i] = (kind_q[i] == MLFT_KIND_DYNAMIC || kind_q[i] == MLFT_KIND_STATIC) &&
				mac_q[i] == i_destination_mac_key && vid_q[i] == i_frm_vid;
			flt_hit[i] = kind_q[i] == MLFT_KIND_FILTER && vid_q[i] == i_frm_vid &&
				(mac_q[i] == i_destination_mac_key || mac_q[i] == i_source_mac_key);
			src_hit[i] = kind_q[i] != MLFT_KIND_FREE && kind_q[i] != MLFT_KIND_FILTER &&
				mac_q[i] == i_source_mac_key && vid_q[i] == i_frm_vid;
			cmd_hit[i] = kind_q[i] != MLFT_KIND_FREE && mac_q[i] == i_cmd_mac && vid_q[i] == i_cmd_vid;
			free_v[i] = kind_q[i] == MLFT_KIND_FREE;
			after_v[i] = (kind_q[i] == MLFT_KIND_DYNAMIC || kind_q[i] == MLFT_KIND_STATIC) &&
				{vid_q[i], mac_q[i]} > cmd_key;
			if (dst_hit[i] && !dst_any) begin
				dst_any = 1'b1;
				dst_idx = IW'(i);
			end
			if (src_hit[i] && !src_any) begin
				src_any = 1'b1;
				src_idx = IW'(i);
			end
			if (cmd_hit[i] && !cmd_any) begin
				cmd_any = 1'b1;
				cmd_idx = IW'(i);
			end
			if (free_v[i] && !free_any) begin
				free_any = 1'b1;
				free_idx = IW'(i);
			end
			if (after_v[i] && (!nxt_any || {vid_q[i], mac_q[i]} < best_key)) begin
				nxt_any = 1'b1;
				nxt_idx = IW'(i);
				best_key = {vid_q[i], mac_q[i]};
			end
		end
	end
	assign flt_any = |flt_hit;

	// ----------------------------------------------------------------
	// Seconds tick and aging time
	// ----------------------------------------------------------------
	assign sec_tick = tick_cnt_q == TICK_LAST;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_q <= '0;
			age_time_q <= MLFT_AGE_RESET_S;
		end else if (i_ce) begin
			tick_cnt_q <= sec_tick ? '0 : tick_cnt_q + TW'(1);
			if (i_cmd_valid && i_cmd_op == MLFT_CMD_SET_AGE)
				age_time_q <= i_cmd_age;
		end
	end

	// ----------------------------------------------------------------
	// Entry update: learning, aging, commands
	// ----------------------------------------------------------------
	logic learn_new, learn_old, flush_now;
	assign flush_now = i_cmd_valid && i_cmd_op == MLFT_CMD_FLUSH;
	assign learn_old = i_frm_valid && src_any && kind_q[src_idx] == MLFT_KIND_DYNAMIC && !flush_now;
	assign learn_new = i_frm_valid && !src_any && free_any && !flt_any;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				kind_q[i] <= MLFT_KIND_FREE;
				mac_q[i] <= '0;
				vid_q[i] <= '0;
				ports_q[i] <= '0;
				idle_q[i] <= MLFT_AGE_ZERO;
			end
		end else if (i_ce) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (kind_q[i] == MLFT_KIND_DYNAMIC && sec_tick) begin
					if (idle_q[i] >= age_time_q)
						kind_q[i] <= MLFT_KIND_FREE;
					else
						idle_q[i] <= idle_q[i] + MLFT_AGE_ONE;
				end
				if (i_cmd_valid && i_cmd_op == MLFT_CMD_FLUSH && kind_q[i] == MLFT_KIND_DYNAMIC)
					kind_q[i] <= MLFT_KIND_FREE;
			end
			if (learn_old) begin
				ports_q[src_idx] <= i_frm_ingress;
				idle_q[src_idx] <= MLFT_AGE_ZERO;
				kind_q[src_idx] <= MLFT_KIND_DYNAMIC;
			end else if (learn_new) begin
				kind_q[free_idx] <= MLFT_KIND_DYNAMIC;
				mac_q[free_idx] <= i_source_mac_key;
				vid_q[free_idx] <= i_frm_vid;
				ports_q[free_idx] <= i_frm_ingress;
				idle_q[free_idx] <= MLFT_AGE_ZERO;
			end
			if (i_cmd_valid) begin
				if (i_cmd_op == MLFT_CMD_ADD_STATIC || i_cmd_op == MLFT_CMD_ADD_FILTER) begin
					if (cmd_any || free_any) begin
						kind_q[cmd_any ? cmd_idx : free_idx] <= (i_cmd_op == MLFT_CMD_ADD_STATIC) ?
							MLFT_KIND_STATIC : MLFT_KIND_FILTER;
						mac_q[cmd_any ? cmd_idx : free_idx] <= i_cmd_mac;
						vid_q[cmd_any ? cmd_idx : free_idx] <= i_cmd_vid;
						ports_q[cmd_any ? cmd_idx : free_idx] <= i_cmd_ports;
					end
				end else if (i_cmd_op == MLFT_CMD_DELETE && cmd_any) begin
					kind_q[cmd_idx] <= MLFT_KIND_FREE;
				end else if (i_cmd_op == MLFT_CMD_PROMOTE && cmd_any &&
					kind_q[cmd_idx] == MLFT_KIND_DYNAMIC) begin
					kind_q[cmd_idx] <= MLFT_KIND_STATIC;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Forwarding decision and read-back outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fwd_valid <= 1'b0;
			o_fwd_drop <= 1'b0;
			o_fwd_flood <= 1'b0;
			o_fwd_ports <= '0;
			o_cmd_done <= 1'b0;
			o_rd_found <= 1'b0;
			o_rd_mac <= '0;
			o_rd_vid <= '0;
			o_rd_static <= 1'b0;
			o_rd_ports <= '0;
		end else if (i_ce) begin
			o_fwd_valid <= i_frm_valid;
			o_fwd_drop <= i_frm_valid && flt_any;
			o_fwd_flood <= i_frm_valid && !flt_any && !dst_any;
			o_fwd_ports <= (!i_frm_valid || flt_any) ? '0 :
				dst_any ? ports_q[dst_idx] : (i_vlan_members & ~i_frm_ingress);
			o_cmd_done <= i_cmd_valid;
			if (i_cmd_valid && i_cmd_op == MLFT_CMD_READ_NEXT) begin
				o_rd_found <= nxt_any;
				o_rd_mac <= nxt_any ? mac_q[nxt_idx] : '0;
				o_rd_vid <= nxt_any ? vid_q[nxt_idx] : '0;
				o_rd_static <= nxt_any && kind_q[nxt_idx] == MLFT_KIND_STATIC;
				o_rd_ports <= nxt_any ? ports_q[nxt_idx] : '0;
			end
		end
	end
	assign o_age_time = age_time_q;
endmodule // mlft_table
`default_nettype wire

// >>> tb/mlft_table_properties.sv
/* Port assertions for the forwarding table.
   Assumes one clock and an async active-low reset. */
`default_nettype none
module mlft_table_properties import mlft_pkg::*; #(
	parameter int PORTS = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_frm_valid,
	input wire logic [PORTS-1:0] i_frm_ingress,
	input wire logic [PORTS-1:0] i_vlan_members,
	input wire logic o_fwd_valid,
	input wire logic o_fwd_drop,
	input wire logic o_fwd_flood,
	input wire logic [PORTS-1:0] o_fwd_ports,
	input wire logic i_cmd_valid,
	input wire logic [mlft_pkg::MLFT_CMD_W-1:0] i_cmd_op,
	input wire logic [mlft_pkg::MLFT_AGE_W-1:0] i_cmd_age,
	input wire logic o_cmd_done,
	input wire logic [mlft_pkg::MLFT_AGE_W-1:0] o_age_time
);
	logic [PORTS-1:0] flood_q;
	wire frm = i_frm_valid && i_ce;
	wire cmd = i_cmd_valid && i_ce;
	wire age_wr = cmd && i_cmd_op == MLFT_CMD_SET_AGE;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	always_ff @(posedge i_sys_clk) if (i_ce) flood_q <= i_vlan_members & ~i_frm_ingress;
	a_fwd_answer: assert property (frm |=> o_fwd_valid) else $error("no answer");
	a_fwd_cause: assert property (o_fwd_valid |-> $past(frm)) else $error("stray answer");
	a_flood_ports: assert property (frm ##1 o_fwd_flood |-> o_fwd_ports == flood_q)
		else $error("bad flood");
	a_drop_empty: assert property (o_fwd_drop |-> o_fwd_ports == '0) else $error("drop ports");
	a_cmd_done: assert property (cmd |=> o_cmd_done) else $error("no done");
	a_done_cause: assert property (o_cmd_done |-> $past(cmd)) else $error("stray done");
	a_age_write: assert property (age_wr |=> o_age_time == $past(i_cmd_age)) else $error("age");
	a_age_hold: assert property (!age_wr |=> $stable(o_age_time)) else $error("age moved");
	c_flood: cover property (o_fwd_valid && o_fwd_flood);
	c_drop: cover property (o_fwd_valid && o_fwd_drop);
	c_age: cover property (age_wr);
endmodule // mlft_table_properties
bind mlft_table mlft_table_properties #(.PORTS(PORTS)) u_props (.i_sys_clk, .i_rst_n, .i_ce, .i_frm_valid,
	.i_frm_ingress, .i_vlan_members, .o_fwd_valid, .o_fwd_drop, .o_fwd_flood, .o_fwd_ports, .i_cmd_valid,
	.i_cmd_op, .i_cmd_age, .o_cmd_done, .o_age_time);
`default_nettype wire

// >>> tb/mlft_frame_src.sv
/* Frame pipeline model: one frame pulse per call.
   Assumes the table answers one cycle later. */
`default_nettype none
module mlft_frame_src (
	input wire logic i_sys_clk,
	output logic o_valid,
	output logic [47:0] o_destination_mac_key,
	output logic [47:0] o_source_mac_key,
	output logic [12:0] o_vid,
	output logic [7:0] o_ing
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {o_valid, o_destination_mac_key, o_source_mac_key, o_vid, o_ing} = '0;
	// Released keys show their inverse
	task automatic send(input logic [47:0] d, s, input logic [12:0] v, input logic [7:0] g);
		@(posedge i_sys_clk);
		{o_valid, o_destination_mac_key, o_source_mac_key, o_vid, o_ing} <= {1'b1, d, s, v, g};
		@(posedge i_sys_clk);
		{o_valid, o_destination_mac_key, o_source_mac_key} <= {1'b0, ~d, ~s};
		#1;
	endtask
endmodule // mlft_frame_src
`default_nettype wire

// >>> tb/test_mlft_table.sv
/* Bench: learning, statics, filters, reads, flush, delete, aging.
   Assumes the frame model and checker are compiled first. */
`default_nettype none
module test_mlft_table import mlft_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk, i_rst_n, i_ce, i_frm_valid, i_cmd_valid, o_fwd_valid, o_fwd_drop, o_fwd_flood;
	logic o_cmd_done, o_rd_found, o_rd_static;
	logic [47:0] i_destination_mac_key, i_source_mac_key, i_cmd_mac, o_rd_mac;
	logic [12:0] i_frm_vid, i_cmd_vid, o_rd_vid;
	logic [7:0] i_frm_ingress, i_vlan_members, o_fwd_ports, i_cmd_ports, o_rd_ports;
	logic [2:0] i_cmd_op;
	logic [9:0] i_cmd_age, o_age_time;
	int bad_count = 0;
	int comparisons = 0;
	mlft_table #(.CYCLES_PER_SEC(10)) dut (.i_sys_clk, .i_rst_n, .i_ce, .i_frm_valid, .i_destination_mac_key,
		.i_source_mac_key, .i_frm_vid, .i_frm_ingress, .i_vlan_members, .o_fwd_valid, .o_fwd_drop, .o_fwd_flood,
		.o_fwd_ports, .i_cmd_valid, .i_cmd_op, .i_cmd_mac, .i_cmd_vid, .i_cmd_ports, .i_cmd_age, .o_cmd_done,
		.o_rd_found, .o_rd_mac, .o_rd_vid, .o_rd_static, .o_rd_ports, .o_age_time);
	mlft_frame_src u_fp (.i_sys_clk, .o_valid(i_frm_valid), .o_destination_mac_key(i_destination_mac_key),
		.o_source_mac_key(i_source_mac_key), .o_vid(i_frm_vid), .o_ing(i_frm_ingress));
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [71:0] e, g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Age value rides in the low key bits
	task automatic cmd(input logic [2:0] op, input logic [47:0] m, input logic [12:0] v, input logic [7:0] p);
		@(posedge i_sys_clk);
		{i_cmd_valid, i_cmd_op, i_cmd_mac, i_cmd_vid, i_cmd_ports, i_cmd_age} <= {1'b1, op, m, v, p, m[9:0]};
		@(posedge i_sys_clk);
		i_cmd_valid <= 1'b0;
		#1;
		chk("done", 1, o_cmd_done);
	endtask
	task automatic fwd(input logic [47:0] d, s, input logic [12:0] v, input logic [7:0] g, e);
		u_fp.send(d, s, v, g);
		chk("fwd", {1'b1, e}, {o_fwd_valid, o_fwd_ports});
	endtask
	task automatic rd(input logic [47:0] m, input logic [12:0] v, input logic [71:0] e);
		cmd(MLFT_CMD_READ_NEXT, m, v, 8'h00);
		chk("rd", e, {o_rd_found, o_rd_static, o_rd_vid, o_rd_mac, o_rd_ports});
	endtask
	task automatic t_learn;
		chk("age", 10'h12C, o_age_time);
		fwd(48'h0F0, 48'h0A0, 13'h003, 8'h02, 8'hD9);
		chk("flood", 1, o_fwd_flood);
		fwd(48'h0A0, 48'h0B0, 13'h003, 8'h04, 8'h02);
		chk("flood", 0, o_fwd_flood);
	endtask
	task automatic t_static;
		cmd(MLFT_CMD_ADD_STATIC, 48'h010, 13'h005, 8'h10);
		fwd(48'h010, 48'h0C0, 13'h005, 8'h01, 8'h10);
		chk("drop", 0, o_fwd_drop);
		cmd(MLFT_CMD_ADD_FILTER, 48'h020, 13'h005, 8'h00);
		fwd(48'h020, 48'h0C0, 13'h005, 8'h01, 8'h00);
		chk("drop", 1, o_fwd_drop);
		cmd(MLFT_CMD_ADD_FILTER, 48'h030, 13'h1000, 8'h00);
		fwd(48'h030, 48'h0D0, 13'h1000, 8'h01, 8'h00);
		chk("drop", 1, o_fwd_drop);
	endtask
	task automatic t_read;
		rd(48'h0, 13'h0, {2'b10, 13'h003, 48'h0A0, 8'h02});
		rd(48'h0A0, 13'h003, {2'b10, 13'h003, 48'h0B0, 8'h04});
		rd(48'h0B0, 13'h003, {2'b11, 13'h005, 48'h010, 8'h10});
		rd(48'h010, 13'h005, {2'b10, 13'h005, 48'h0C0, 8'h01});
	endtask
	task automatic t_promote_flush;
		cmd(MLFT_CMD_PROMOTE, 48'h0A0, 13'h003, 8'h00);
		cmd(MLFT_CMD_FLUSH, 48'h0, 13'h0, 8'h00);
		rd(48'h0, 13'h0, {2'b11, 13'h003, 48'h0A0, 8'h02});
		rd(48'h0A0, 13'h003, {2'b11, 13'h005, 48'h010, 8'h10});
		cmd(MLFT_CMD_READ_NEXT, 48'h010, 13'h005, 8'h00);
		chk("found", 0, o_rd_found);
	endtask
	task automatic t_delete_age;
		cmd(MLFT_CMD_DELETE, 48'h010, 13'h005, 8'h00);
		fwd(48'h010, 48'h0A0, 13'h005, 8'h01, 8'hDA);
		cmd(MLFT_CMD_SET_AGE, 48'h00A, 13'h0, 8'h00);
		chk("age", 10'h00A, o_age_time);
		fwd(48'h0F0, 48'h0E0, 13'h007, 8'h08, 8'hD3);
		fwd(48'h0E0, 48'h0F0, 13'h007, 8'h01, 8'h08);
		repeat (80) @(posedge i_sys_clk);
		fwd(48'h0E0, 48'h0F0, 13'h007, 8'h01, 8'h08);
		repeat (70) @(posedge i_sys_clk);
		fwd(48'h0E0, 48'h0B0, 13'h007, 8'h01, 8'hDA);
		fwd(48'h0F0, 48'h0A0, 13'h003, 8'h08, 8'hD3);
		fwd(48'h0A0, 48'h0B0, 13'h003, 8'h04, 8'h02);
	endtask
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		{i_rst_n, i_cmd_valid, i_cmd_op, i_cmd_mac, i_cmd_vid, i_cmd_ports, i_cmd_age} = '0;
		{i_ce, i_vlan_members} = {1'b1, 8'hDB};
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_learn();
		t_static();
		t_read();
		t_promote_flush();
		t_delete_age();
		report_and_stop();
	end
	initial begin
		repeat (3000) @(posedge i_sys_clk);
		bad_count++;
		report_and_stop();
	end
endmodule // test_mlft_table
`default_nettype wire
